// File: design/wwdt_top.sv
// Purpose: Windowed watchdog timer with APB registers and fuse boot load.
// Assumes: The watchdog oscillator is an asynchronous input, sampled here.
// Notes: One clock domain; rising oscillator edges become one-cycle ticks.
//
// Contract
// - Nonzero period code enables the watchdog.
// - Normal mode resets when no clear arrives.
// - Accepted clear restarts a fresh period.
// - Eleven period codes, eight ms to eight s.
// - Zero window field means normal mode.
// - Nonzero window field enables window mode.
// - Clear during closed period resets system.
// - Open period follows closed period directly.
// - Missing clear in open period resets.
// - Window checking starts after first clear.
// - Lock blocks config writes; a guarded status write in debug clears lock.
// - Fuse loads config; nonzero period sets lock.
// - Protected writes need the guard unlock.
// - Counter advances on watchdog oscillator ticks.
// - Keeps counting, outside debug halt, while the oscillator runs.
// - Debug halt stops and zeroes the counter.
// - After debug, one normal timeout runs first.
// - Config moves to counter side with busy.
// - Clear applies after two oscillator ticks.
// - Codes map to eight doubling to 8K ticks.
// - Busy sets on write, clears when done.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module wwdt_top
    import wwdt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [WWDT_ADDR_W-1:0] paddr,
    input wire logic [WWDT_DATA_W-1:0] pwdata,
    output logic [WWDT_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchdogOscClock,
    input wire logic watchdogClearInstr,
    input wire logic configChangeGuard,
    input wire logic debugHalt,
    input wire wwdt_fuse_t bootConfigFuse,
    output logic sysResetReq
);

    wwdt_state_t st_ff;
    wwdt_state_t nxt_st;

    logic oscTick;
    logic ctrlSel;
    logic statusSel;
    logic wrAccess;
    logic ctrlWrOk;
    logic lockWr;
    logic clrApply;
    logic syncDone;
    logic [13:0] periodTicks;
    logic [13:0] windowTicks;
    logic windowMode;

    // Ticks for a code; reserved codes are held at the longest period.
    function automatic logic [13:0] code_ticks(input logic [3:0] code);
        logic [3:0] c;
        c = (code > WWDT_CODE_MAX) ? WWDT_CODE_MAX : code;
        code_ticks = WWDT_BASE_TICKS << (c - 4'h1);
    endfunction

    // Bus decode from the live bus inputs, and the oscillator tick from held state.
    always_comb
    begin
        ctrlSel = (paddr[WWDT_ADDR_W-1:2] == WWDT_CTRL_IDX);
        statusSel = (paddr[WWDT_ADDR_W-1:2] == WWDT_STATUS_IDX);
        wrAccess = psel && penable && st_ff.pready && pwrite;
        // Only the agreeing second and third stages are trusted.
        oscTick = (st_ff.osc2 == st_ff.osc3) && st_ff.osc3 && !st_ff.oscLvl;
        // Guard and lock both gate the configuration word.
        ctrlWrOk = wrAccess && ctrlSel && configChangeGuard && !st_ff.lock;
        lockWr = wrAccess && statusSel && configChangeGuard;
        syncDone = st_ff.sync_pending_flag && oscTick
                   && (st_ff.syncCnt == WWDT_SYNC_TICKS - 2'h1);
        // A clear is applied on its second oscillator tick.
        clrApply = st_ff.clrPend && oscTick
                   && (st_ff.clrCnt == WWDT_SYNC_TICKS - 2'h1);
        periodTicks = code_ticks(st_ff.effPeriod);
        windowTicks = code_ticks(st_ff.effWindow);
        windowMode = (st_ff.effWindow != WWDT_CODE_OFF);
    end

    // Next state of the whole block.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.resetReq = 1'b0;

        // Three-stage sampler for the free-running oscillator.
        nxt_st.osc1 = watchdogOscClock;
        nxt_st.osc2 = st_ff.osc1;
        nxt_st.osc3 = st_ff.osc2;
        if (st_ff.osc2 == st_ff.osc3)
        begin
            nxt_st.oscLvl = st_ff.osc3;
        end

        // APB answers in the first access cycle with registered data.
        nxt_st.pready = psel && !penable;
        nxt_st.pslverr = psel && !penable && !ctrlSel && !statusSel;
        nxt_st.prdata = WWDT_WORD_RST;
        if (psel && !penable && ctrlSel)
        begin
            nxt_st.prdata[WWDT_WINDOW_LSB +: WWDT_FIELD_W] = st_ff.window;
            nxt_st.prdata[WWDT_PERIOD_LSB +: WWDT_FIELD_W] = st_ff.period;
        end
        else if (psel && !penable && statusSel)
        begin
            nxt_st.prdata[WWDT_LOCK_BIT] = st_ff.lock;
            nxt_st.prdata[WWDT_BUSY_BIT] = st_ff.sync_pending_flag;
        end

        // The boot image is taken once, on the first edge after reset.
        if (!st_ff.booted)
        begin
            nxt_st.booted = 1'b1;
            nxt_st.period = bootConfigFuse.period;
            nxt_st.window = bootConfigFuse.window;
            nxt_st.effPeriod = bootConfigFuse.period;
            nxt_st.effWindow = bootConfigFuse.window;
            nxt_st.lock = (bootConfigFuse.period != WWDT_CODE_OFF);
            nxt_st.phase = (bootConfigFuse.period != WWDT_CODE_OFF)
                           ? WWDT_NORMAL : WWDT_OFF;
            nxt_st.cnt = WWDT_CNT_RST;
        end
        else
        begin
            // Lock may be set by software, and cleared only in debug.
            if (lockWr && pwdata[WWDT_LOCK_BIT])
            begin
                nxt_st.lock = 1'b1;
            end
            else if (lockWr && debugHalt)
            begin
                nxt_st.lock = 1'b0;
            end

            // Configuration transfer: a new write restarts it.
            if (st_ff.sync_pending_flag && oscTick)
            begin
                nxt_st.syncCnt = st_ff.syncCnt + 2'h1;
            end
            if (syncDone)
            begin
                nxt_st.sync_pending_flag = 1'b0;
                nxt_st.effPeriod = st_ff.period;
                nxt_st.effWindow = st_ff.window;
            end
            // A write in the finishing cycle wins over the clear.
            if (ctrlWrOk)
            begin
                nxt_st.period = pwdata[WWDT_PERIOD_LSB +: WWDT_FIELD_W];
                nxt_st.window = pwdata[WWDT_WINDOW_LSB +: WWDT_FIELD_W];
                nxt_st.sync_pending_flag = 1'b1;
                nxt_st.syncCnt = WWDT_SCNT_RST;
            end

            // Clear instruction crossing toward the counter.
            if (st_ff.clrPend && oscTick)
            begin
                nxt_st.clrCnt = st_ff.clrCnt + 2'h1;
            end
            if (clrApply)
            begin
                nxt_st.clrPend = 1'b0;
            end
            // A new pulse in the applying cycle is kept, not merged.
            if (watchdogClearInstr && (!st_ff.clrPend || clrApply))
            begin
                nxt_st.clrPend = 1'b1;
                nxt_st.clrCnt = WWDT_SCNT_RST;
            end

            // Counter phases; runs in any sleep state with ticks.
            if (debugHalt)
            begin
                // Halted: no timeout, start over after the halt.
                nxt_st.cnt = WWDT_CNT_RST;
                nxt_st.phase = (st_ff.effPeriod != WWDT_CODE_OFF)
                               ? WWDT_NORMAL : WWDT_OFF;
                nxt_st.clrPend = 1'b0;
            end
            else if (syncDone && st_ff.period == WWDT_CODE_OFF)
            begin
                nxt_st.phase = WWDT_OFF;
                nxt_st.cnt = WWDT_CNT_RST;
            end
            else if (syncDone && st_ff.phase == WWDT_OFF)
            begin
                // Newly enabled: window checking waits for a clear.
                nxt_st.phase = WWDT_NORMAL;
                nxt_st.cnt = WWDT_CNT_RST;
            end
            else if (syncDone && st_ff.window == WWDT_CODE_OFF
                     && st_ff.phase != WWDT_NORMAL)
            begin
                nxt_st.phase = WWDT_NORMAL;
                nxt_st.cnt = WWDT_CNT_RST;
            end
            else if (st_ff.phase != WWDT_OFF)
            begin
                if (clrApply && st_ff.phase == WWDT_CLOSED)
                begin
                    // Too early a clear is a violation.
                    nxt_st.resetReq = 1'b1;
                    nxt_st.phase = WWDT_NORMAL;
                    nxt_st.cnt = WWDT_CNT_RST;
                end
                else if (clrApply)
                begin
                    nxt_st.cnt = WWDT_CNT_RST;
                    nxt_st.phase = windowMode
                                   ? WWDT_CLOSED : WWDT_NORMAL;
                end
                else if (oscTick && st_ff.phase == WWDT_CLOSED)
                begin
                    nxt_st.cnt = st_ff.cnt + 14'h0001;
                    if (st_ff.cnt + 14'h0001 >= windowTicks)
                    begin
                        nxt_st.phase = WWDT_OPEN;
                        nxt_st.cnt = WWDT_CNT_RST;
                    end
                end
                else if (oscTick)
                begin
                    nxt_st.cnt = st_ff.cnt + 14'h0001;
                    if (st_ff.cnt + 14'h0001 >= periodTicks)
                    begin
                        // Late or missing clear.
                        nxt_st.resetReq = 1'b1;
                        nxt_st.phase = WWDT_NORMAL;
                        nxt_st.cnt = WWDT_CNT_RST;
                    end
                end
            end
        end
    end

    // State register; reset takes constants only, fuse loads later.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= '{osc1: 1'b0, osc2: 1'b0, osc3: 1'b0, oscLvl: 1'b0,
                booted: 1'b0, period: WWDT_FIELD_RST,
                window: WWDT_FIELD_RST, effPeriod: WWDT_FIELD_RST,
                effWindow: WWDT_FIELD_RST, lock: 1'b0, sync_pending_flag: 1'b0,
                syncCnt: WWDT_SCNT_RST, clrPend: 1'b0,
                clrCnt: WWDT_SCNT_RST, phase: WWDT_OFF,
                cnt: WWDT_CNT_RST, resetReq: 1'b0, pready: 1'b0,
                pslverr: 1'b0, prdata: WWDT_WORD_RST};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign sysResetReq = st_ff.resetReq;

    // Checks on the block's own behaviour.
    a_reset_single_pulse: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        st_ff.resetReq |=> !st_ff.resetReq)
        else $error("Reset request lasted more than one cycle.");

    a_off_no_reset: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.booted && st_ff.phase == WWDT_OFF) |=> !st_ff.resetReq)
        else $error("Reset requested while the watchdog was off.");

    a_lock_sticky: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.lock && !debugHalt) |=> st_ff.lock)
        else $error("Lock cleared outside debug halt.");

    a_locked_ctrl_hold: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.booted && st_ff.lock)
        |=> $stable({st_ff.period, st_ff.window}))
        else $error("Configuration changed while locked.");

    a_guard_reject: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.booted && !configChangeGuard)
        |=> $stable({st_ff.period, st_ff.window}))
        else $error("Configuration changed without the guard open.");

    a_busy_on_write: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ctrlWrOk |=> st_ff.sync_pending_flag ##0 (st_ff.syncCnt == WWDT_SCNT_RST))
        else $error("Busy flag not raised by a configuration write.");

    a_debug_zeroes: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.booted && debugHalt)
        |=> (st_ff.cnt == WWDT_CNT_RST) && !st_ff.resetReq)
        else $error("Counter not held at zero during debug halt.");

    a_debug_normal: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.booted && debugHalt && st_ff.effPeriod != WWDT_CODE_OFF)
        |=> st_ff.phase == WWDT_NORMAL)
        else $error("Debug halt left the window phases armed.");

    a_early_clear: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clrApply && st_ff.phase == WWDT_CLOSED && !debugHalt
         && !syncDone) |=> st_ff.resetReq)
        else $error("Clear in closed period did not reset.");

    a_clear_restart: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clrApply && st_ff.phase == WWDT_NORMAL && !debugHalt && !syncDone)
        |=> (st_ff.cnt == WWDT_CNT_RST) && !st_ff.resetReq)
        else $error("Clear did not restart the period.");

    a_window_arms: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clrApply && st_ff.phase == WWDT_NORMAL && windowMode
         && !debugHalt && !syncDone)
        |=> st_ff.phase == WWDT_CLOSED)
        else $error("Clear did not start the closed period.");

    a_closed_to_open: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (oscTick && !clrApply && st_ff.phase == WWDT_CLOSED
         && st_ff.cnt + 14'h0001 >= windowTicks && !debugHalt && !syncDone)
        |=> st_ff.phase == WWDT_OPEN)
        else $error("Closed period did not hand over to the open period.");

    a_timeout_resets: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (oscTick && !clrApply && !debugHalt && !syncDone
         && (st_ff.phase == WWDT_NORMAL || st_ff.phase == WWDT_OPEN)
         && st_ff.cnt + 14'h0001 >= periodTicks)
        |=> st_ff.resetReq)
        else $error("Expired period did not request a reset.");

    a_busy_clears: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (syncDone && !ctrlWrOk) |=> !st_ff.sync_pending_flag)
        else $error("Busy flag stayed up after the transfer finished.");

    a_fuse_lock_load: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!st_ff.booted && bootConfigFuse.period != WWDT_CODE_OFF)
        |=> st_ff.lock && st_ff.phase == WWDT_NORMAL)
        else $error("Nonzero boot period did not lock and enable.");

    a_clear_set_wins: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.booted && watchdogClearInstr && !debugHalt
         && (!st_ff.clrPend || clrApply)) |=> st_ff.clrPend)
        else $error("Clear instruction was lost.");

    a_unmapped_error: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (psel && !penable && !ctrlSel && !statusSel)
        |=> st_ff.pslverr && st_ff.pready)
        else $error("Unmapped access did not answer with an error.");

    a_pready_single: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        st_ff.pready |=> !st_ff.pready)
        else $error("Ready held for more than one cycle.");

endmodule // wwdt_top

`default_nettype wire

// File: design/wwdt_pkg.sv
// Purpose: Shared constants and types for the windowed watchdog timer.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes: Register indices are word indices; byte address is four times.
package wwdt_pkg;

    // Register word indices and data width.
    localparam logic [5:0] WWDT_CTRL_IDX = 6'h00;
    localparam logic [5:0] WWDT_STATUS_IDX = 6'h01;
    localparam int WWDT_ADDR_W = 8;
    localparam int WWDT_DATA_W = 32;

    // Field positions in the configuration and status words.
    localparam int WWDT_PERIOD_LSB = 0;
    localparam int WWDT_WINDOW_LSB = 4;
    localparam int WWDT_FIELD_W = 4;
    localparam int WWDT_LOCK_BIT = 7;
    localparam int WWDT_BUSY_BIT = 0;

    // Period codes: zero is off, one to eleven double from eight ticks.
    localparam logic [3:0] WWDT_CODE_OFF = 4'h0;
    localparam logic [3:0] WWDT_CODE_MAX = 4'hB;
    localparam int WWDT_CNT_W = 14;
    localparam logic [13:0] WWDT_BASE_TICKS = 14'h0008;

    // Oscillator ticks spent moving writes and clears into the counter.
    localparam logic [1:0] WWDT_SYNC_TICKS = 2'h2;

    // Reset values.
    localparam logic [3:0] WWDT_FIELD_RST = 4'h0;
    localparam logic [13:0] WWDT_CNT_RST = 14'h0000;
    localparam logic [1:0] WWDT_SCNT_RST = 2'h0;
    localparam logic [31:0] WWDT_WORD_RST = 32'h0000_0000;

    // Counter phases.
    typedef enum logic [1:0] {
        WWDT_OFF,
        WWDT_NORMAL,
        WWDT_CLOSED,
        WWDT_OPEN
    } wwdt_phase_t;

    // Boot fuse image: window and period codes.
    typedef struct packed {
        logic [3:0] window;
        logic [3:0] period;
    } wwdt_fuse_t;

    // Whole state of the block.
    typedef struct packed {
        logic osc1;
        logic osc2;
        logic osc3;
        logic oscLvl;
        logic booted;
        logic [3:0] period;
        logic [3:0] window;
        logic [3:0] effPeriod;
        logic [3:0] effWindow;
        logic lock;
        logic sync_pending_flag;
        logic [1:0] syncCnt;
        logic clrPend;
        logic [1:0] clrCnt;
        wwdt_phase_t phase;
        logic [13:0] cnt;
        logic resetReq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } wwdt_state_t;

endpackage

// File: bench/wwdt_core_model.sv
// Purpose: Processor core model that issues APB transfers and clears.
// Assumes: The slave raises pready; the bench waits out reset first.
// Notes: After time zero, every signal changes by non-blocking assignment after an edge.
`timescale 1ns/1ps
`default_nettype none

module wwdt_core_model
    import wwdt_pkg::*;
(
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [WWDT_ADDR_W-1:0] paddr,
    output logic [WWDT_DATA_W-1:0] pwdata,
    input wire logic [WWDT_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic clearInstr,
    output logic guard
);
    // Idle bus at time zero so nothing is requested during reset.
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        clearInstr = 1'b0;
        guard = 1'b0;
    end

    // One transfer; the request holds until pready is sampled high.
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic g,
        output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        guard <= g;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        guard <= 1'b0;
    endtask

    // A clear instruction is a one-cycle pulse in the system clock.
    task automatic clear_pulse();
        @(posedge clk_sys);
        clearInstr <= 1'b1;
        @(posedge clk_sys);
        clearInstr <= 1'b0;
    endtask
endmodule // wwdt_core_model

`default_nettype wire

// File: bench/tb_windowed_watchdog_timer.sv
// Purpose: Self-checking bench for the windowed watchdog timer.
// Assumes: The oscillator runs at 42 ns so timeouts stay short.
// Notes: One tick is 10.5 system cycles; resets are counted as pulses.
`timescale 1ns/1ps
`default_nettype none

module tb_windowed_watchdog_timer;
    import wwdt_pkg::*;
    logic clk_sys, nrst, psel, penable, pwrite, osc, clr, guard, dbg;
    logic pready, pslverr, rstReq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    wwdt_fuse_t fuse;
    int errTotal = 0, samplesChecked = 0, rstSeen = 0, cyc = 0, b;

    wwdt_top u_wwdt_top (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdogOscClock(osc), .watchdogClearInstr(clr),
        .configChangeGuard(guard), .debugHalt(dbg),
        .bootConfigFuse(fuse), .sysResetReq(rstReq));

    wwdt_core_model u_wwdt_core_model (.clk_sys(clk_sys), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clearInstr(clr), .guard(guard));

    // The oscillator is faster than real but free running and unrelated.
    initial
    begin
        clk_sys = 1'b0;
        osc = 1'b0;
        fork
            forever #2 clk_sys = ~clk_sys;
            forever #21 osc = ~osc;
        join
    end

    // Count reset pulses and cut a hang short.
    always @(posedge clk_sys)
    begin
        if (rstReq === 1'b1)
            rstSeen++;
        cyc++;
        if (cyc == 30000)
        begin
            errTotal++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("unexpected at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        u_wwdt_core_model.xfer(1'b0, a, 32'h0000_0000, 1'b0, d, e);
    endtask

    // Polls the busy flag, bounded, before a write is allowed.
    task automatic wait_idle();
        logic [31:0] s;
        int i;
        i = 0;
        rd(8'h04, s);
        while (s[0] !== 1'b0 && i < 60)
        begin
            rd(8'h04, s);
            i++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic g);
        logic [31:0] s;
        logic e;
        wait_idle();
        u_wwdt_core_model.xfer(1'b1, a, d, g, s, e);
    endtask

    task automatic clear_and_mark();
        u_wwdt_core_model.clear_pulse();
    endtask

    // Lines a scenario up just after a reset pulse, so an old count
    // cannot expire while a clear is still crossing over.
    task automatic await_reset();
        do @(posedge clk_sys); while (rstReq !== 1'b1);
        @(posedge clk_sys);
    endtask

    task automatic t_boot();
        rd(8'h00, r);
        check(r, 32'h0000_0001);
        rd(8'h04, r);
        check(r, 32'h0000_0080);
        repeat (110) @(posedge clk_sys);
        check(32'(rstSeen), 32'h0000_0001);
    endtask

    task automatic t_lock_debug();
        wr(8'h00, 32'h0000_0003, 1'b1);
        rd(8'h00, r);
        check(r, 32'h0000_0001);
        wr(8'h04, 32'h0000_0000, 1'b1);
        rd(8'h04, r);
        check(r, 32'h0000_0080);
        dbg <= 1'b1;
        repeat (20) @(posedge clk_sys);
        b = rstSeen;
        repeat (300) @(posedge clk_sys);
        check(32'(rstSeen - b), 32'h0000_0000);
        wr(8'h04, 32'h0000_0000, 1'b1);
        rd(8'h04, r);
        check(r, 32'h0000_0000);
        dbg <= 1'b0;
    endtask

    task automatic t_guard();
        logic e;
        wr(8'h00, 32'h0000_0005, 1'b0);
        rd(8'h00, r);
        check(r, 32'h0000_0001);
        wr(8'h04, 32'h0000_0080, 1'b0);
        rd(8'h04, r);
        check(r, 32'h0000_0000);
        u_wwdt_core_model.xfer(1'b0, 8'h08, 32'h0000_0000, 1'b0, r, e);
        check(32'(e), 32'h0000_0001);
        wr(8'h00, 32'h0000_0000, 1'b1);
        wait_idle();
        b = rstSeen;
        repeat (200) @(posedge clk_sys);
        check(32'(rstSeen - b), 32'h0000_0000);
    endtask

    // Every period code; the short ones are also timed after a clear.
    task automatic t_codes();
        int t;
        for (int n = 1; n <= 11; n++)
        begin
            wr(8'h00, 32'(n), 1'b1);
            rd(8'h04, r);
            check(32'(r[0]), 32'h0000_0001);
            rd(8'h00, r);
            check(r, 32'(n));
            if (n <= 3)
            begin
                t = int'(WWDT_BASE_TICKS) << (n - 1);
                wait_idle();
                await_reset();
                clear_and_mark();
                b = rstSeen;
                repeat (t * 21 / 2) @(posedge clk_sys);
                check(32'(rstSeen - b), 32'h0000_0000);
                repeat (40) @(posedge clk_sys);
                check(32'(rstSeen - b), 32'h0000_0001);
            end
        end
    endtask

    task automatic t_restart();
        wr(8'h00, 32'h0000_0002, 1'b1);
        wait_idle();
        await_reset();
        b = rstSeen;
        repeat (5)
        begin
            clear_and_mark();
            repeat (100) @(posedge clk_sys);
        end
        check(32'(rstSeen - b), 32'h0000_0000);
        repeat (200) @(posedge clk_sys);
        check(32'(rstSeen - b), 32'h0000_0001);
    endtask

    // Closed is 8 ticks, open is 16 ticks.
    task automatic t_window();
        wr(8'h00, 32'h0000_0012, 1'b1);
        wait_idle();
        await_reset();
        b = rstSeen;
        clear_and_mark();
        repeat (40) @(posedge clk_sys);
        clear_and_mark();
        repeat (50) @(posedge clk_sys);
        check(32'(rstSeen - b), 32'h0000_0001);
        clear_and_mark();
        repeat (140) @(posedge clk_sys);
        clear_and_mark();
        repeat (200) @(posedge clk_sys);
        check(32'(rstSeen - b), 32'h0000_0001);
        repeat (120) @(posedge clk_sys);
        check(32'(rstSeen - b), 32'h0000_0002);
    endtask

    initial
    begin
        nrst = 1'b0;
        dbg = 1'b0;
        fuse = 8'h01;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_boot();
        t_lock_debug();
        t_guard();
        t_codes();
        t_restart();
        t_window();
        report_and_stop();
    end
endmodule // tb_windowed_watchdog_timer

`default_nettype wire
